// >>> core/rss_pkg.sv
// package: reset-cause status register map, field layout and cause rows
`default_nettype none
package rss_pkg;
   // register bus geometry
   localparam int RSS_ADDR_W = 12;
   localparam int RSS_DATA_W = 8;
   localparam logic [11:0] RSS_STATUS_OFS = 12'hFF0;
   // bit positions inside the status byte
   localparam int RSS_POR_BIT = 7;
   localparam int RSS_SLEEP_BIT = 6;
   localparam int RSS_WDT_BIT = 5;
   localparam int RSS_EXT_BIT = 4;
   localparam int RSS_LOW_BIT = 0;
   // reserved field bits 3..1 read as zero
   localparam logic [2:0] RSS_RSV_VAL = 3'h0;
   // cause vector order: {power_on, sleep_recovery, watchdog, ext_pin}
   localparam logic [3:0] RSS_ROW_POR = 4'h8;
   localparam logic [3:0] RSS_ROW_EXT = 4'h1;
   localparam logic [3:0] RSS_ROW_WDT_RST = 4'h2;
   localparam logic [3:0] RSS_ROW_PIN_WAKE = 4'h4;
   localparam logic [3:0] RSS_ROW_WDT_WAKE = 4'h6;
   localparam logic [3:0] RSS_ROW_NONE = 4'h0;
   // value after reset: a reset of this block counts as power-on
   localparam logic [3:0] RSS_CAUSE_RST = RSS_ROW_POR;
   localparam logic [7:0] RSS_RDATA_RST = 8'h00;
   // unmapped reads answer with this value
   localparam logic [7:0] RSS_UNMAPPED_VAL = 8'h00;
endpackage
`default_nettype wire

// >>> core/rss_status.sv
// module: reset-cause status register with read-to-clear cause flags
`default_nettype none
module rss_status
   import rss_pkg::*;
#(
   parameter int ADDR_W = RSS_ADDR_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // reset and recovery events, one-cycle pulses
   input wire logic por_event,
   input wire logic ext_pin_reset,
   input wire logic wdt_timeout,
   input wire logic dbg_ctl_reset,
   input wire logic gpio_wake,
   // levels
   input wire logic sleep_mode,
   input wire logic debug_pin,
   input wire logic supply_low,
   // flag mirrors for the sequencer
   output logic power_on_flag,
   output logic sleep_recovery_flag,
   output logic watchdog_flag,
   output logic ext_pin_flag,
   output logic low_supply_flag
);

   // assemble the status byte from the cause vector and live supply bit
   // the reserved field is a constant, so no store can make it read non-zero
   function automatic logic [7:0] status_byte(input logic [3:0] cause,
                                               input logic low);
      status_byte = {cause, RSS_RSV_VAL, low};
   endfunction

   logic [3:0] cause_q;
   logic [3:0] cause_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic low_q;

   // address decode; writes are ignored since the register is read-only
   // so a stray store to this offset cannot wipe a recorded cause
   wire logic rd_hit;
   wire logic wr_unused;
   assign rd_hit = rd_en && (addr == ADDR_W'(RSS_STATUS_OFS));
   assign wr_unused = wr_en & (|wr_data);

   // event qualification; wakes only count while asleep
   // debug_pin is a level: held low while asleep it reloads the power-on
   // row every cycle, harmless since the part leaves sleep at once
   wire logic dbg_pin_wake;
   wire logic pin_wake;
   wire logic wdt_wake;
   wire logic wdt_reset;
   wire logic poweron_like;
   assign dbg_pin_wake = sleep_mode && !debug_pin;
   assign pin_wake = sleep_mode && gpio_wake;
   assign wdt_wake = sleep_mode && wdt_timeout;
   assign wdt_reset = !sleep_mode && wdt_timeout;
   assign poweron_like = por_event || dbg_ctl_reset || dbg_pin_wake;

   // row of the highest-priority event this cycle
   // power-on class beats pin reset, beats watchdog, beats pin wake
   // only one row can stand, so when causes coincide the one software
   // most needs to see is kept and the weaker ones are dropped on purpose
   wire logic any_event;
   wire logic [3:0] event_row;
   assign any_event = poweron_like || ext_pin_reset || wdt_timeout
                      || pin_wake;
   assign event_row =
      poweron_like  ? RSS_ROW_POR :
      ext_pin_reset ? RSS_ROW_EXT :
      wdt_wake      ? RSS_ROW_WDT_WAKE :
      wdt_reset     ? RSS_ROW_WDT_RST :
      pin_wake      ? RSS_ROW_PIN_WAKE :
                      RSS_ROW_NONE;

   // next cause: an event wins over the read clear so no cause is lost
   assign cause_d = any_event ? event_row :
                    rd_hit    ? RSS_ROW_NONE : cause_q;

   // read data holds the value seen in the read cycle, before clearing
   // other offsets answer zero so a wired-or read mux can merge this byte
   assign rdata_d = rd_hit ? status_byte(cause_q, supply_low)
                           : RSS_UNMAPPED_VAL;

   // cause flags; reset of this block is treated as a power-on
   // a read and an event in one cycle are resolved in cause_d, not here
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cause_q <= RSS_CAUSE_RST;
      end else begin
         cause_q <= cause_d;
      end
   end

   // read data and the low-supply mirror; supply is never latched
   // the read path uses the live pin, so software sees the detector as it
   // stands in the read cycle; low_q only feeds the sequencer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= RSS_RDATA_RST;
         low_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         low_q <= supply_low;
      end
   end

   // outputs straight from flops
   assign rd_data = rdata_q;
   assign power_on_flag = cause_q[3];
   assign sleep_recovery_flag = cause_q[2];
   assign watchdog_flag = cause_q[1];
   assign ext_pin_flag = cause_q[0];
   assign low_supply_flag = low_q;

   // checks: off during reset, whose value the bench checks after release
   // a cause lost here would send software down the wrong recovery path
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // helper: registered copies of the qualifying conditions
   // row_p lets the race check compare with the row chosen in the read
   // cycle itself, hit_p shows the read really was taken there
   logic hit_p;
   logic evt_p;
   logic [3:0] row_p;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hit_p <= 1'b0;
         evt_p <= 1'b0;
         row_p <= RSS_ROW_NONE;
      end else begin
         hit_p <= rd_hit;
         evt_p <= any_event;
         row_p <= event_row;
      end
   end

   // power-on class events report POR only
   chk_por_row: assert property (
      por_event |=> (cause_q == RSS_ROW_POR))
      else $error("power-on event not reported as power-on only");

   chk_dbg_reset: assert property (
      dbg_ctl_reset |=> power_on_flag && !sleep_recovery_flag
                        && !watchdog_flag && !ext_pin_flag)
      else $error("debugger reset not reported like power-on");

   chk_dbg_pin: assert property (
      (sleep_mode && !debug_pin) |=> (cause_q == RSS_ROW_POR))
      else $error("debug pin wake not reported like power-on");

   // watchdog and sleep events clear power-on unless a power-on arrives
   chk_por_clear: assert property (
      ((wdt_timeout || pin_wake) && !poweron_like) |=> !power_on_flag)
      else $error("power-on flag survived watchdog or wake");

   chk_pin_wake: assert property (
      (pin_wake && !poweron_like && !ext_pin_reset && !wdt_timeout)
      |=> (cause_q == RSS_ROW_PIN_WAKE))
      else $error("pin wake row wrong");

   chk_wdt_wake: assert property (
      (wdt_wake && !poweron_like && !ext_pin_reset)
      |=> sleep_recovery_flag && watchdog_flag
          && !power_on_flag && !ext_pin_flag)
      else $error("watchdog wake row wrong");

   chk_sleep_set: assert property (
      ((pin_wake || wdt_wake) && !poweron_like && !ext_pin_reset)
      |=> sleep_recovery_flag)
      else $error("sleep recovery flag not set on wake");

   chk_wdt_awake: assert property (
      (wdt_reset && !poweron_like && !ext_pin_reset)
      |=> !sleep_recovery_flag && watchdog_flag)
      else $error("awake watchdog time-out row wrong");

   chk_ext_row: assert property (
      (ext_pin_reset && !poweron_like)
      |=> (cause_q == RSS_ROW_EXT))
      else $error("external reset row wrong");

   // quiet read clears all cause flags and returns the old value
   chk_read_clear: assert property (
      (rd_hit && !any_event) |=> (cause_q == RSS_ROW_NONE))
      else $error("read did not clear cause flags");

   chk_read_sleep: assert property (
      (rd_hit && !any_event) |=> !sleep_recovery_flag && !power_on_flag)
      else $error("read did not clear sleep or power-on flag");

   chk_read_data: assert property (
      rd_hit |=> (rd_data[7:4] == $past(cause_q)))
      else $error("read data not the pre-read cause value");

   chk_read_wdt: assert property (
      (rd_hit && !any_event) |=> (!watchdog_flag && !ext_pin_flag)
                                 ##1 (evt_p || !watchdog_flag))
      else $error("read did not clear watchdog or ext flags");

   // set wins: event in the read cycle still shows afterwards
   chk_set_wins: assert property (
      (rd_hit && any_event) |=> (cause_q == row_p) && hit_p
                                && (cause_q != RSS_ROW_NONE))
      else $error("event lost to a read clear");

   chk_wdt_set: assert property (
      (wdt_timeout && !poweron_like && !ext_pin_reset)
      |=> watchdog_flag)
      else $error("watchdog flag not set on time-out");

   chk_pin_clears: assert property (
      (pin_wake && !poweron_like && !ext_pin_reset && !wdt_timeout)
      |=> !watchdog_flag && !ext_pin_flag)
      else $error("pin wake left watchdog or ext flag set");

   // a pin change while awake is no wake and leaves the flags alone
   chk_gpio_awake: assert property (
      (gpio_wake && !sleep_mode && !poweron_like && !ext_pin_reset
       && !wdt_timeout && !rd_hit) |=> $stable(cause_q))
      else $error("pin change while awake changed the cause flags");

   chk_por_clears: assert property (
      poweron_like |=> !ext_pin_flag && !watchdog_flag)
      else $error("power-on left ext or watchdog flag set");

   chk_por_sleep: assert property (
      poweron_like |=> power_on_flag && !sleep_recovery_flag)
      else $error("power-on left sleep recovery flag set");

   // reserved bits zero, low bit is the live supply sample
   chk_rsv_zero: assert property (
      ##1 (rd_data[3:1] == RSS_RSV_VAL))
      else $error("reserved bits not zero");

   chk_low_live: assert property (
      rd_hit |=> (rd_data[0] == $past(supply_low))
                 && (low_supply_flag == $past(supply_low)))
      else $error("low supply bit not live");

   // the mirror follows the detector one cycle late, in every cycle
   chk_low_mirror: assert property (
      !$past(sys_rst) |-> (low_supply_flag == $past(supply_low)))
      else $error("low supply flag does not follow the detector");

   // unmapped reads answer zero
   chk_unmapped: assert property (
      !rd_hit |=> (rd_data == RSS_UNMAPPED_VAL))
      else $error("read data outside a mapped read");

   // a read of another offset is not a read of the status register
   chk_stray_read: assert property (
      (rd_en && !rd_hit && !any_event) |=> $stable(cause_q))
      else $error("stray read changed the cause flags");

   // flags stand still while nothing happens
   chk_hold: assert property (
      (!any_event && !rd_hit) |=> $stable(cause_q))
      else $error("cause flags changed with no cause");

   // main scenarios
   cov_wdt_wake: cover property (
      wdt_wake ##1 rd_hit ##1 (rd_data[7:4] == RSS_ROW_WDT_WAKE));
   cov_ext_read: cover property (
      ext_pin_reset ##[1:4] rd_hit);
   cov_race: cover property (rd_hit && any_event);
   cov_low: cover property (rd_hit && supply_low);

   // writes have no effect; kept to show the port is decoded
   cov_write: cover property (wr_en && wr_unused);

endmodule
`default_nettype wire

// >>> sim/rss_status_tb.sv
// testbench: reset-cause status register, cause events and read-to-clear
`default_nettype none
module rss_status_tb import rss_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, wr_en, rd_en, sleep_mode, debug_pin, supply_low;
   logic [11:0] addr;
   logic [7:0] wr_data, rd_data;
   logic [4:0] pulse; // {por, ext, wdt, dbg, gpio}
   logic pof, srf, wdf, epf, lsf;
   int n_fail, cmp_count, cyc;

   rss_status u_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .por_event(pulse[4]), .ext_pin_reset(pulse[3]),
      .wdt_timeout(pulse[2]), .dbg_ctl_reset(pulse[1]),
      .gpio_wake(pulse[0]), .sleep_mode(sleep_mode), .debug_pin(debug_pin),
      .supply_low(supply_low), .power_on_flag(pof),
      .sleep_recovery_flag(srf), .watchdog_flag(wdf), .ext_pin_flag(epf),
      .low_supply_flag(lsf));

   // 50 ns period
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmpf(string what, logic [3:0] exp);
      cmp_count++;
      if ({pof, srf, wdf, epf} !== exp) begin
         n_fail++;
         $display("[FAIL] %s flags expected %h seen %h", what, exp,
            {pof, srf, wdf, epf});
      end
   endtask

   // read data is looked at in the one cycle where it stands
   task automatic rd(logic [11:0] a, logic [7:0] exp, string what);
      @(posedge clk);
      rd_en <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'h0;
      @(negedge clk);
      cmp8(what, exp, rd_data);
   endtask

   // one-cycle event, levels return to awake with debug_pin high
   task automatic ev(logic [1:0] lv, logic [4:0] p);
      @(posedge clk);
      {sleep_mode, debug_pin} <= lv;
      pulse <= p;
      @(posedge clk);
      {sleep_mode, debug_pin} <= 2'h1;
      pulse <= 5'h00;
      @(negedge clk);
   endtask

   // hang guard, the whole run needs well under 300 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end

   initial begin
      {sys_rst, wr_en, rd_en, sleep_mode, supply_low} = 5'h10;
      debug_pin = 1'h1;
      addr = 12'h000;
      wr_data = 8'h00;
      pulse = 5'h00;
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      @(negedge clk);
      cmpf("after reset", RSS_ROW_POR);
      cmp8("low flag after reset", 8'h00, {7'h00, lsf});
      rd(RSS_STATUS_OFS, 8'h80, "first read");
      cmpf("after read", RSS_ROW_NONE);
      rd(RSS_STATUS_OFS, 8'h00, "second read");
      $display("test reset done");
      // every cause row; each event but the awake pin change overwrites the row that stood before
      ev(2'h1, 5'h08);
      cmpf("ext reset row", RSS_ROW_EXT);
      ev(2'h1, 5'h04);
      cmpf("awake watchdog row", RSS_ROW_WDT_RST);
      rd(RSS_STATUS_OFS, 8'h20, "awake watchdog read");
      cmpf("watchdog read clear", RSS_ROW_NONE);
      ev(2'h1, 5'h02);
      cmpf("debugger reset row", RSS_ROW_POR);
      ev(2'h3, 5'h04);
      cmpf("watchdog wake row", RSS_ROW_WDT_WAKE);
      rd(RSS_STATUS_OFS, 8'h60, "watchdog wake read");
      cmpf("wake read clear", RSS_ROW_NONE);
      ev(2'h3, 5'h04);
      ev(2'h3, 5'h01);
      cmpf("pin wake row", RSS_ROW_PIN_WAKE);
      ev(2'h1, 5'h08);
      ev(2'h3, 5'h01);
      cmpf("pin wake after ext", RSS_ROW_PIN_WAKE);
      rd(RSS_STATUS_OFS, 8'h40, "pin wake read");
      ev(2'h2, 5'h00);
      cmpf("debug pin wake row", RSS_ROW_POR);
      ev(2'h1, 5'h10);
      cmpf("power-on row", RSS_ROW_POR);
      ev(2'h1, 5'h01);
      cmpf("awake pin change ignored", RSS_ROW_POR);
      rd(RSS_STATUS_OFS, 8'h80, "power-on read");
      cmpf("power-on read clear", RSS_ROW_NONE);
      $display("test cause table done");
      // watchdog in the very cycle of a read: old value read, event kept
      ev(2'h1, 5'h08);
      @(posedge clk);
      rd_en <= 1'h1;
      addr <= RSS_STATUS_OFS;
      pulse <= 5'h04;
      @(posedge clk);
      rd_en <= 1'h0;
      pulse <= 5'h00;
      @(negedge clk);
      cmp8("read beside event", 8'h10, rd_data);
      cmpf("event beats clear", RSS_ROW_WDT_RST);
      $display("test set wins done");
      // live supply bit survives reads; writes and stray reads do nothing
      @(posedge clk);
      supply_low <= 1'h1;
      rd(RSS_STATUS_OFS, 8'h21, "low supply read");
      rd(RSS_STATUS_OFS, 8'h01, "low supply kept");
      cmp8("low supply flag", 8'h01, {7'h00, lsf});
      @(posedge clk);
      wr_en <= 1'h1;
      wr_data <= 8'hF1; // reserved bits written as zero
      @(posedge clk);
      wr_en <= 1'h0;
      rd(RSS_STATUS_OFS, 8'h01, "after write");
      rd(12'hFF1, RSS_UNMAPPED_VAL, "unmapped read");
      @(posedge clk);
      supply_low <= 1'h0;
      rd(RSS_STATUS_OFS, 8'h00, "supply back");
      cmp8("low supply flag clear", 8'h00, {7'h00, lsf});
      $display("test supply and map done");
      // second reset in mid-run after a sleep wake
      ev(2'h3, 5'h01);
      cmpf("wake before reset", RSS_ROW_PIN_WAKE);
      @(posedge clk);
      sys_rst <= 1'h1;
      @(posedge clk);
      sys_rst <= 1'h0;
      @(negedge clk);
      cmpf("mid-run reset", RSS_ROW_POR);
      $display("test second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
